// *** inc/imucal_defs.svh ***
`ifndef IMUCAL_DEFS_SVH
`define IMUCAL_DEFS_SVH

// ****************************************
// Paging
// ****************************************
`define IMUCAL_PAGE_ADDR 7'h00
`define IMUCAL_PAGE_RST 8'h00
`define IMUCAL_CAL_PAGE 8'h02
`define IMUCAL_CFG_PAGE 8'h03

// ****************************************
// Calibration word offsets
// ****************************************
`define IMUCAL_GYRO_X_GAIN_OFS 7'h04
`define IMUCAL_GYRO_Y_GAIN_OFS 7'h06
`define IMUCAL_GYRO_Z_GAIN_OFS 7'h08
`define IMUCAL_GYRO_X_LOW_OFS 7'h10
`define IMUCAL_GYRO_X_UP_OFS 7'h12
`define IMUCAL_GYRO_Y_LOW_OFS 7'h14
`define IMUCAL_GYRO_Y_UP_OFS 7'h16
`define IMUCAL_GYRO_Z_LOW_OFS 7'h18
`define IMUCAL_GYRO_Z_UP_OFS 7'h1a
`define IMUCAL_ACC_X_LOW_OFS 7'h1c
`define IMUCAL_ACC_X_UP_OFS 7'h1e
`define IMUCAL_ACC_Y_LOW_OFS 7'h20
`define IMUCAL_ACC_Y_UP_OFS 7'h22
`define IMUCAL_ACC_Z_LOW_OFS 7'h24
`define IMUCAL_ACC_Z_UP_OFS 7'h26
`define IMUCAL_CFG_OFS 7'h0a

// ****************************************
// Word store slots
// ****************************************
`define IMUCAL_SLOT_GAIN 4'h0
`define IMUCAL_SLOT_LOW 4'h3
`define IMUCAL_SLOT_NONE 4'hf
`define IMUCAL_CAL_RST 16'h0000

// ****************************************
// Options control fields
// ****************************************
`define IMUCAL_CFG_RST 16'h00c0
`define IMUCAL_CFG_WMASK 8'hc3
`define IMUCAL_CFG_LING_BIT 7
`define IMUCAL_CFG_ALIGN_BIT 6
`define IMUCAL_CFG_DST_BIT 1
`define IMUCAL_CFG_RTCREL_BIT 0

// ****************************************
// Serial frame fields
// ****************************************
`define IMUCAL_FRAME_BITS 5'd16
`define IMUCAL_GAIN_SHIFT 15

`endif

// *** inc/imucal_pkg.sv ***
package imucal_pkg;

  typedef enum logic [2:0] {
    IMUCAL_GYRO_X = 3'b000,
    IMUCAL_GYRO_Y = 3'b001,
    IMUCAL_GYRO_Z = 3'b010,
    IMUCAL_ACC_X = 3'b100,
    IMUCAL_ACC_Y = 3'b101,
    IMUCAL_ACC_Z = 3'b110
  } imucal_axis_e;

  typedef enum logic [2:0] {
    IMUCAL_IDLE = 3'b000,
    IMUCAL_GAIN = 3'b001,
    IMUCAL_LOW = 3'b010,
    IMUCAL_HIGH = 3'b011,
    IMUCAL_APPLY = 3'b100
  } imucal_state_e;

  typedef logic [3:0] imucal_slot_t;

endpackage : imucal_pkg

// *** logic/imucal_word_store.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "imucal_defs.svh"

module imucal_word_store (
  input wire logic clock,
  input wire logic resetn,
  input wire logic ce,
  input wire logic wrEn,
  input wire imucal_pkg::imucal_slot_t wrIdx,
  input wire logic [1:0] wrBe,
  input wire logic [15:0] wrData,
  input wire imucal_pkg::imucal_slot_t rdIdxA,
  output logic [15:0] rdDataA,
  input wire imucal_pkg::imucal_slot_t rdIdxB,
  output logic [15:0] rdDataB
);
  import imucal_pkg::*;

  logic [15:0] words [16];

  // Every slot clears so no gain or offset correction applies after reset
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < 16; i++) begin
        words[i] <= `IMUCAL_CAL_RST;
      end
    end else if (ce && wrEn) begin
      if (wrBe[0]) begin
        words[wrIdx][7:0] <= wrData[7:0];
      end
      if (wrBe[1]) begin
        words[wrIdx][15:8] <= wrData[15:8];
      end
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rdDataA <= 16'h0000;
      rdDataB <= 16'h0000;
    end else if (ce) begin
      rdDataA <= words[rdIdxA];
      rdDataB <= words[rdIdxB];
    end
  end

  byte_write_a: assert property (@(posedge clock) disable iff (!resetn)
    ce && wrEn && wrBe[1] |=> words[$past(wrIdx)][15:8] == $past(wrData[15:8]))
    else $error("upper byte not stored");

endmodule : imucal_word_store

`default_nettype wire

// *** logic/imucal_regs.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "imucal_defs.svh"

// How it works
// - Each gyro axis adds its own offset built from upper and lower words.
// - Gyro upper offset word is signed, zero means none, step 0.02 deg/s.
// - Gyro lower word extends upper word by 16 bits into one 32-bit offset.
// - Gyro gain trim is signed; zero is unity, step one part in 2^15.
// - Each accel axis adds a signed upper offset word, step 0.8 milli-g.
// - Accel lower word extends upper word into one 32-bit offset.
// - Accel offset words share the accel output upper and lower encodings.
// - All gain and offset words reset to zero, no gain or offset correction.
// - Options bit 7 turns linear-g gyro bias compensation on.
// - Options bit 6 turns point-of-percussion alignment on.
// - Options register resets to 0x00C0 with both clock bits cleared.
// - Options bit 1 turns daylight-saving clock adjustment on.
// - Options bit 0 picks elapsed-timer clock mode, else calendar mode.
// - Gyro bias shift from linear acceleration is corrected when enabled.
module imucal_regs (
  input wire logic clock,
  input wire logic resetn,
  input wire logic ce,
  input wire logic spiCsN,
  input wire logic spiSclk,
  input wire logic spiDin,
  output logic spiDout,
  output logic spiDoutOe,
  input wire logic sampleValid,
  output logic sampleReady,
  input wire imucal_pkg::imucal_axis_e sampleAxis,
  input wire logic [31:0] sampleData,
  input wire logic [31:0] linGTerm,
  output logic resultValid,
  output imucal_pkg::imucal_axis_e resultAxis,
  output logic [31:0] resultData,
  output logic linearGEnable,
  output logic alignEnable,
  output logic dstEnable,
  output logic rtcElapsedMode
);
  import imucal_pkg::*;

  // ****************************************
  // Functions
  // ****************************************
  // Slot of a page-2 byte address, none when unmapped
  function automatic imucal_slot_t slotOf(input logic [6:0] addr);
    logic [6:0] even;
    even = {addr[6:1], 1'b0};
    case (even)
      `IMUCAL_GYRO_X_GAIN_OFS: slotOf = 4'h0;
      `IMUCAL_GYRO_Y_GAIN_OFS: slotOf = 4'h1;
      `IMUCAL_GYRO_Z_GAIN_OFS: slotOf = 4'h2;
      `IMUCAL_GYRO_X_LOW_OFS: slotOf = 4'h3;
      `IMUCAL_GYRO_X_UP_OFS: slotOf = 4'h4;
      `IMUCAL_GYRO_Y_LOW_OFS: slotOf = 4'h5;
      `IMUCAL_GYRO_Y_UP_OFS: slotOf = 4'h6;
      `IMUCAL_GYRO_Z_LOW_OFS: slotOf = 4'h7;
      `IMUCAL_GYRO_Z_UP_OFS: slotOf = 4'h8;
      `IMUCAL_ACC_X_LOW_OFS: slotOf = 4'h9;
      `IMUCAL_ACC_X_UP_OFS: slotOf = 4'ha;
      `IMUCAL_ACC_Y_LOW_OFS: slotOf = 4'hb;
      `IMUCAL_ACC_Y_UP_OFS: slotOf = 4'hc;
      `IMUCAL_ACC_Z_LOW_OFS: slotOf = 4'hd;
      `IMUCAL_ACC_Z_UP_OFS: slotOf = 4'he;
      default: slotOf = `IMUCAL_SLOT_NONE;
    endcase
  endfunction : slotOf

  // Lower offset slot of an axis; the upper word is the next slot
  function automatic imucal_slot_t lowSlot(input imucal_axis_e ax);
    logic [3:0] pos;
    pos = {1'b0, ax[2] ? 3'(ax[1:0] + 2'd3) : {1'b0, ax[1:0]}};
    lowSlot = 4'(`IMUCAL_SLOT_LOW + {pos[2:0], 1'b0});
  endfunction : lowSlot

  // Clamp a wide signed sum to 32 bits
  function automatic logic [31:0] sat32(input logic signed [49:0] v);
    if (v > 50'sh0_0000_7fff_ffff) begin
      sat32 = 32'h7fff_ffff;
    end else if (v < -50'sh0_0000_8000_0000) begin
      sat32 = 32'h8000_0000;
    end else begin
      sat32 = v[31:0];
    end
  endfunction : sat32

  // ****************************************
  // Serial pin synchronisers
  // ****************************************
  logic [2:0] csSync;
  logic [2:0] sclkSync;
  logic [1:0] dinSync;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      csSync <= 3'b111;
      sclkSync <= 3'b111;
      dinSync <= 2'b00;
    end else if (ce) begin
      csSync <= {csSync[1:0], spiCsN};
      sclkSync <= {sclkSync[1:0], spiSclk};
      dinSync <= {dinSync[0], spiDin};
    end
  end

  logic csLow;
  logic csFall;
  logic csRise;
  logic sclkRise;
  logic sclkFall;
  assign csLow = !csSync[1];
  assign csFall = !csSync[1] && csSync[2];
  assign csRise = csSync[1] && !csSync[2];
  assign sclkRise = sclkSync[1] && !sclkSync[2];
  assign sclkFall = !sclkSync[1] && sclkSync[2];

  // ****************************************
  // Frame shifter
  // ****************************************
  logic [15:0] rxShift;
  logic [15:0] txShift;
  logic [15:0] txNext;
  logic [4:0] bitCount;

  // Short frames are dropped at the rising chip select
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rxShift <= 16'h0000;
      bitCount <= 5'd0;
    end else if (ce) begin
      if (csFall) begin
        bitCount <= 5'd0;
      end else if (csLow && sclkRise && bitCount != `IMUCAL_FRAME_BITS) begin
        rxShift <= {rxShift[14:0], dinSync[1]};
        bitCount <= 5'(bitCount + 5'd1);
      end
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      txShift <= 16'h0000;
    end else if (ce) begin
      if (csFall) begin
        txShift <= txNext;
      end else if (csLow && sclkFall && bitCount != 5'd0) begin
        // First fall only opens the MSB cell in mode 3, so no shift then
        txShift <= {txShift[14:0], 1'b0};
      end
    end
  end

  assign spiDout = txShift[15];
  assign spiDoutOe = csLow;

  logic frameDone;
  logic isWrite;
  logic [6:0] frameAddr;
  logic [7:0] frameData;
  imucal_slot_t frameSlot;
  assign frameDone = csRise && bitCount == `IMUCAL_FRAME_BITS;
  assign isWrite = rxShift[15];
  assign frameAddr = rxShift[14:8];
  assign frameData = rxShift[7:0];
  assign frameSlot = slotOf(frameAddr);

  // ****************************************
  // Page and options registers
  // ****************************************
  logic [7:0] page;
  logic [15:0] options;
  logic calHit;
  logic cfgLowWrite;
  assign calHit = page == `IMUCAL_CAL_PAGE && frameSlot != `IMUCAL_SLOT_NONE;
  assign cfgLowWrite = frameDone && isWrite && page == `IMUCAL_CFG_PAGE
    && frameAddr == `IMUCAL_CFG_OFS;

  // Page select answers on every page
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      page <= `IMUCAL_PAGE_RST;
    end else if (ce && frameDone && isWrite && frameAddr == `IMUCAL_PAGE_ADDR) begin
      page <= frameData;
    end
  end

  // Upper byte holds no fields, so its write is dropped
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      options <= `IMUCAL_CFG_RST;
    end else if (ce && cfgLowWrite) begin
      options <= {8'h00, frameData & `IMUCAL_CFG_WMASK};
    end
  end

  assign linearGEnable = options[`IMUCAL_CFG_LING_BIT];
  assign alignEnable = options[`IMUCAL_CFG_ALIGN_BIT];
  assign dstEnable = options[`IMUCAL_CFG_DST_BIT];
  assign rtcElapsedMode = options[`IMUCAL_CFG_RTCREL_BIT];

  // ****************************************
  // Read-back for the next frame
  // ****************************************
  logic rdPend;
  logic rdMem;
  logic rdCfg;
  logic rdPage;
  logic [15:0] memRdA;
  logic [15:0] memRdB;
  imucal_slot_t slotB;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rdPend <= 1'b0;
      rdMem <= 1'b0;
      rdCfg <= 1'b0;
      rdPage <= 1'b0;
    end else if (ce) begin
      rdPend <= frameDone && !isWrite;
      if (frameDone && !isWrite) begin
        rdMem <= calHit;
        rdCfg <= page == `IMUCAL_CFG_PAGE && frameAddr == `IMUCAL_CFG_OFS;
        rdPage <= frameAddr == `IMUCAL_PAGE_ADDR;
      end
    end
  end

  // Unmapped reads answer zero
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      txNext <= 16'h0000;
    end else if (ce && rdPend) begin
      if (rdMem) begin
        txNext <= memRdA;
      end else if (rdCfg) begin
        txNext <= options;
      end else if (rdPage) begin
        txNext <= {8'h00, page};
      end else begin
        txNext <= 16'h0000;
      end
    end
  end

  imucal_word_store u_store (
    .clock(clock),
    .resetn(resetn),
    .ce(ce),
    .wrEn(frameDone && isWrite && calHit),
    .wrIdx(frameSlot),
    .wrBe(frameAddr[0] ? 2'b10 : 2'b01),
    .wrData({frameData, frameData}),
    .rdIdxA(frameSlot),
    .rdDataA(memRdA),
    .rdIdxB(slotB),
    .rdDataB(memRdB)
  );

  // ****************************************
  // Correction path
  // ****************************************
  imucal_state_e state;
  imucal_axis_e axis;
  logic [31:0] raw;
  logic [31:0] linG;
  logic [15:0] gainW;
  logic [15:0] lowW;
  logic isGyro;
  assign isGyro = !axis[2];
  assign sampleReady = state == IMUCAL_IDLE;

  always_comb begin
    case (state)
      IMUCAL_GAIN: slotB = 4'(`IMUCAL_SLOT_GAIN + {2'b00, axis[1:0]});
      IMUCAL_LOW: slotB = lowSlot(axis);
      IMUCAL_HIGH: slotB = 4'(lowSlot(axis) + 4'h1);
      default: slotB = `IMUCAL_SLOT_NONE;
    endcase
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state <= IMUCAL_IDLE;
    end else if (ce) begin
      case (state)
        IMUCAL_IDLE: state <= sampleValid ? IMUCAL_GAIN : IMUCAL_IDLE;
        IMUCAL_GAIN: state <= IMUCAL_LOW;
        IMUCAL_LOW: state <= IMUCAL_HIGH;
        IMUCAL_HIGH: state <= IMUCAL_APPLY;
        IMUCAL_APPLY: state <= IMUCAL_IDLE;
        default: state <= IMUCAL_IDLE;
      endcase
    end
  end

  // Accel gain trims live outside this bank, so accel runs at unity
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      axis <= IMUCAL_GYRO_X;
      raw <= 32'h0000_0000;
      linG <= 32'h0000_0000;
      gainW <= 16'h0000;
      lowW <= 16'h0000;
    end else if (ce) begin
      if (state == IMUCAL_IDLE && sampleValid) begin
        axis <= sampleAxis;
        raw <= sampleData;
        linG <= linGTerm;
      end
      if (state == IMUCAL_LOW) begin
        gainW <= isGyro ? memRdB : 16'h0000;
      end
      if (state == IMUCAL_HIGH) begin
        lowW <= memRdB;
      end
    end
  end

  logic signed [47:0] scaled;
  logic signed [31:0] bias;
  logic signed [31:0] linGUse;
  logic signed [49:0] total;
  // Offset words pair exactly like the accel output words
  assign scaled = 48'(($signed({raw, 15'h0000}) + $signed(raw) * $signed(gainW))
    >>> `IMUCAL_GAIN_SHIFT);
  assign bias = $signed({memRdB, lowW});
  assign linGUse = (isGyro && options[`IMUCAL_CFG_LING_BIT]) ? $signed(linG) : 32'sd0;
  assign total = 50'(scaled) + 50'(bias) - 50'(linGUse);

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      resultValid <= 1'b0;
      resultAxis <= IMUCAL_GYRO_X;
      resultData <= 32'h0000_0000;
    end else if (ce) begin
      resultValid <= state == IMUCAL_APPLY;
      if (state == IMUCAL_APPLY) begin
        resultAxis <= axis;
        resultData <= sat32(total);
      end
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  sample_latency_a: assert property (@(posedge clock) disable iff (!resetn || !ce)
    sampleValid && sampleReady |-> ##5 resultValid && resultAxis == $past(sampleAxis, 5))
    else $error("result not five cycles after sample");

  result_pulse_a: assert property (@(posedge clock) disable iff (!resetn || !ce)
    resultValid |-> sampleReady ##1 !resultValid)
    else $error("result valid longer than a cycle");

  options_reset_a: assert property (@(posedge clock) disable iff (!resetn)
    $rose(resetn) |-> options == `IMUCAL_CFG_RST)
    else $error("options not at reset value");

  options_write_a: assert property (@(posedge clock) disable iff (!resetn || !ce)
    cfgLowWrite |=> linearGEnable == $past(frameData[7]) && alignEnable == $past(frameData[6])
      && dstEnable == $past(frameData[1]) && rtcElapsedMode == $past(frameData[0]))
    else $error("options bits not taken");

  options_unused_a: assert property (@(posedge clock) disable iff (!resetn)
    options[15:8] == 8'h00 && options[5:2] == 4'h0)
    else $error("unused options bits set");

  page_select_a: assert property (@(posedge clock) disable iff (!resetn || !ce)
    frameDone && isWrite && frameAddr == `IMUCAL_PAGE_ADDR |=> page == $past(frameData))
    else $error("page not selected");

  zero_cal_a: assert property (@(posedge clock) disable iff (!resetn || !ce)
    state == IMUCAL_APPLY && gainW == 16'h0000 && memRdB == 16'h0000 && lowW == 16'h0000
      && linGUse == 32'sd0 |=> resultData == $past(raw))
    else $error("zero correction changed sample");

  ling_off_a: assert property (@(posedge clock) disable iff (!resetn || !ce)
    state == IMUCAL_APPLY && !isGyro |-> linGUse == 32'sd0)
    else $error("linear-g applied to accel");

endmodule : imucal_regs

`default_nettype wire

// *** tb/imucal_spi_host.sv ***
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// Serial host model, mode 3, MSB first
// ****************************************
module imucal_spi_host (
  input wire logic clock,
  output logic spiCsN,
  output logic spiSclk,
  output logic spiDin,
  input wire logic spiDout,
  input wire logic spiDoutOe
);
  // Half period well above the two clocks the synchronisers need
  localparam int HALF = 5;

  initial begin
    spiCsN = 1'b1;
    spiSclk = 1'b1;
    spiDin = 1'b0;
  end

  task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
    rx = 16'h0000;
    @(negedge clock);
    spiCsN = 1'b0;
    repeat (HALF) @(negedge clock);
    for (int i = 15; i >= 0; i--) begin
      spiSclk = 1'b0;
      spiDin = tx[i];
      repeat (HALF) @(negedge clock);
      // Taken just before the rising edge, as the device expects
      rx[i] = spiDoutOe ? spiDout : ~spiDout;
      spiSclk = 1'b1;
      repeat (HALF) @(negedge clock);
    end
    spiCsN = 1'b1;
    // Released data line must not keep showing the last bit
    spiDin = ~spiDin;
    repeat (2 * HALF) @(negedge clock);
  endtask : xfer
endmodule : imucal_spi_host

`default_nettype wire

// *** tb/imucal_regs_tb.sv ***
`timescale 1ns/1ps
`default_nettype none

module imucal_regs_tb;
  import imucal_pkg::*;

  // ****************************************
  // Stimulus and wiring
  // ****************************************
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic ce = 1'b1;
  wire logic spiCsN;
  wire logic spiSclk;
  wire logic spiDin;
  logic spiDout;
  logic spiDoutOe;
  logic sampleValid = 1'b0;
  logic sampleReady;
  imucal_axis_e sampleAxis = IMUCAL_GYRO_X;
  logic [31:0] sampleData = 32'h00000000;
  logic [31:0] linGTerm = 32'h00000300;
  logic resultValid;
  imucal_axis_e resultAxis;
  logic [31:0] resultData;
  logic linearGEnable;
  logic alignEnable;
  logic dstEnable;
  logic rtcElapsedMode;
  int nFail = 0;
  int checkCount = 0;
  logic [31:0] raw = 32'h00012345;
  logic [31:0] expVal;
  logic [6:0] rstOfs [15] = '{7'h04, 7'h06, 7'h08, 7'h10, 7'h12, 7'h14, 7'h16, 7'h18,
                              7'h1a, 7'h1c, 7'h1e, 7'h20, 7'h22, 7'h24, 7'h26};
  imucal_axis_e axList [6] = '{IMUCAL_GYRO_X, IMUCAL_GYRO_Y, IMUCAL_GYRO_Z,
                               IMUCAL_ACC_X, IMUCAL_ACC_Y, IMUCAL_ACC_Z};
  logic [6:0] lowOfs [6] = '{7'h10, 7'h14, 7'h18, 7'h1c, 7'h20, 7'h24};
  logic [15:0] gainVal [3] = '{16'h4000, 16'h8000, 16'h0001};

  always #2.5 clock = ~clock;

  imucal_regs dut (
    .clock(clock), .resetn(resetn), .ce(ce),
    .spiCsN(spiCsN), .spiSclk(spiSclk), .spiDin(spiDin),
    .spiDout(spiDout), .spiDoutOe(spiDoutOe),
    .sampleValid(sampleValid), .sampleReady(sampleReady), .sampleAxis(sampleAxis),
    .sampleData(sampleData), .linGTerm(linGTerm), .resultValid(resultValid),
    .resultAxis(resultAxis), .resultData(resultData), .linearGEnable(linearGEnable),
    .alignEnable(alignEnable), .dstEnable(dstEnable), .rtcElapsedMode(rtcElapsedMode)
  );

  imucal_spi_host host (
    .clock(clock), .spiCsN(spiCsN), .spiSclk(spiSclk), .spiDin(spiDin),
    .spiDout(spiDout), .spiDoutOe(spiDoutOe)
  );

  // ****************************************
  // Compare and verdict
  // ****************************************
  task automatic check1(input logic got, input logic exp);
    checkCount++;
    if (got !== exp) begin
      nFail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check1

  task automatic check16(input logic [15:0] got, input logic [15:0] exp);
    checkCount++;
    if (got !== exp) begin
      nFail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check16

  task automatic check32(input logic [31:0] got, input logic [31:0] exp);
    checkCount++;
    if (got !== exp) begin
      nFail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check32

  task automatic giveVerdict();
    $display("Comparisons %0d, mismatches %0d", checkCount, nFail);
    if (nFail == 0 && checkCount > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : giveVerdict

  // ****************************************
  // Register access over the serial link
  // ****************************************
  task automatic xw(input logic [15:0] word);
    logic [15:0] r;
    host.xfer(word, r);
  endtask : xw

  task automatic wr16(input logic [6:0] a, input logic [15:0] d);
    xw({1'b1, a, d[7:0]});
    xw({1'b1, a + 7'h01, d[15:8]});
  endtask : wr16

  // Read answer arrives in the following frame
  task automatic expectReg(input logic [6:0] a, input logic [15:0] exp);
    logic [15:0] r;
    host.xfer({1'b0, a, 8'h00}, r);
    host.xfer(16'h0000, r);
    check16(r, exp);
  endtask : expectReg

  function automatic logic [31:0] corr(input logic [31:0] s, input logic [15:0] g,
                                       input logic [31:0] ofs, input logic [31:0] lin);
    logic signed [63:0] acc;
    acc = $signed(s) + (($signed(s) * $signed(g)) >>> 15) + $signed(ofs) - $signed(lin);
    if (acc > 64'sh7fffffff) return 32'h7fffffff;
    if (acc < -64'sh80000000) return 32'h80000000;
    return acc[31:0];
  endfunction : corr

  // Valid is held through two busy cycles with other data, which must be ignored
  task automatic sample(input imucal_axis_e ax, input logic [31:0] s, input logic [31:0] exp);
    @(negedge clock);
    sampleValid = 1'b1;
    sampleAxis = ax;
    sampleData = s;
    @(negedge clock);
    sampleData = ~s;
    repeat (2) @(negedge clock);
    sampleValid = 1'b0;
    repeat (2) @(posedge clock);
    #1;
    check1(resultValid, 1'b1);
    check32(resultData, exp);
    check1(resultAxis === ax, 1'b1);
  endtask : sample

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    repeat (20) @(negedge clock);
    resetn = 1'b1;
    repeat (4) @(negedge clock);
    check1(linearGEnable, 1'b1);
    check1(alignEnable, 1'b1);
    check1(dstEnable, 1'b0);
    check1(rtcElapsedMode, 1'b0);
    xw(16'h8002);
    foreach (rstOfs[i]) expectReg(rstOfs[i], 16'h0000);
    xw(16'h8003);
    expectReg(7'h0a, 16'h00c0);
    sample(IMUCAL_GYRO_Z, raw, corr(raw, 16'h0000, 32'h0, linGTerm));
    sample(IMUCAL_ACC_Y, raw, raw);
    repeat (2) @(negedge clock);
    ce = 1'b0;
    sampleValid = 1'b1;
    repeat (6) @(negedge clock);
    check1(sampleReady, 1'b1);
    check1(resultValid, 1'b0);
    sampleValid = 1'b0;
    ce = 1'b1;
    $display("test reset_defaults done");
    xw(16'h8003);
    xw(16'h8a40);
    xw(16'h8b00);
    check1(linearGEnable, 1'b0);
    check1(alignEnable, 1'b1);
    expectReg(7'h0a, 16'h0040);
    sample(IMUCAL_GYRO_Z, raw, raw);
    xw(16'h8aff);
    expectReg(7'h0a, 16'h00c3);
    check1(dstEnable & rtcElapsedMode & linearGEnable & alignEnable, 1'b1);
    xw(16'h8a00);
    xw(16'h8bff);
    check1(dstEnable | rtcElapsedMode | linearGEnable | alignEnable, 1'b0);
    expectReg(7'h0b, 16'h0000);
    $display("test options done");
    xw(16'h8002);
    for (int i = 0; i < 6; i++) begin
      wr16(lowOfs[i], 16'h8000 + 16'(i));
      wr16(lowOfs[i] + 7'h02, 16'h0010 + 16'(i));
      if (i < 3) begin
        wr16(7'h04 + 7'(2 * i), gainVal[i]);
      end
    end
    for (int i = 0; i < 6; i++) begin
      expectReg(lowOfs[i], 16'h8000 + 16'(i));
      expectReg(lowOfs[i] + 7'h03, 16'h0010 + 16'(i));
      expVal = corr(raw, (i < 3) ? gainVal[i] : 16'h0000,
                    {16'h0010 + 16'(i), 16'h8000 + 16'(i)}, 32'h0);
      sample(axList[i], raw, expVal);
    end
    $display("test offsets_and_gains done");
    wr16(7'h12, 16'h7fff);
    wr16(7'h10, 16'hffff);
    sample(IMUCAL_GYRO_X, 32'h7fff0000, 32'h7fffffff);
    wr16(7'h26, 16'h8000);
    wr16(7'h24, 16'h0000);
    sample(IMUCAL_ACC_Z, 32'h80000000, 32'h80000000);
    $display("test saturation done");
    xw(16'h8005);
    xw(16'h8455);
    xw(16'h8002);
    expectReg(7'h05, 16'h4000);
    expectReg(7'h02, 16'h0000);
    expectReg(7'h00, 16'h0002);
    $display("test refused_access done");
    giveVerdict();
  end

  initial begin
    #400000;
    nFail++;
    giveVerdict();
  end
endmodule : imucal_regs_tb

`default_nettype wire
